/* pkg/gcc_decoder_pkg.sv */
/*
  Shared constants and types for the grid converter command decoder.
  Assumes one converter control clock; the command word arrives from logic on that clock.
*/
package gcc_decoder_pkg;

  // Word geometry and the default command value.
  localparam int          CMD_W       = 16;
  localparam logic [15:0] CMD_DEFAULT = 16'h0005;

  // Command word field positions.
  localparam int B_SWITCH_ON   = 0;
  localparam int B_BREAKER_EN  = 1;
  localparam int B_QSTOP_N     = 2;
  localparam int B_START       = 3;
  localparam int B_PRECHARGE   = 4;
  localparam int B_EVENT_RESET = 7;
  localparam int B_DATA_VALID  = 10;
  localparam int B_WATCHDOG    = 11;
  localparam int B_CFG_LO      = 12;
  localparam int B_CFG_HI      = 15;
  localparam int B_APP_LO      = 4;
  localparam int B_APP_HI      = 10;

  // Condition word field positions.
  localparam int C_READY_ON    = 0;
  localparam int C_POWER_READY = 1;
  localparam int C_OP_ENABLED  = 2;
  localparam int C_FAULT       = 3;
  localparam int C_QSTOP_N     = 5;
  localparam int C_INHIBITED   = 6;

  // Start-up state machine.
  typedef enum logic [2:0] {
    ST_INHIBITED = 3'b000,
    ST_READY     = 3'b001,
    ST_PRECHARGE = 3'b010,
    ST_CLOSE     = 3'b011,
    ST_RUN       = 3'b100
  } start_state_t;

  // Requests driven toward the power stage.
  typedef struct packed {
    logic precharge;
    logic breaker_close;
    logic breaker_open;
    logic run;
    logic modulation_stop;
    logic qstop_exception;
    logic event_reset;
  } power_req_t;

  localparam power_req_t REQ_IDLE = '{default: 1'b0};

endpackage : gcc_decoder_pkg

/* core/cmd_word_latch.sv */
/*
  Holds the accepted command word and flags the bits that rose on each acceptance.
  Assumes the write strobe and word come from logic on clk, so no synchroniser is used.
*/
`timescale 1ns/1ps
`default_nettype none

module cmd_word_latch
  import gcc_decoder_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Incoming word from the fieldbus side.
  input  wire logic [CMD_W-1:0] word_in,
  input  wire logic             word_wr,
  input  wire logic             wdog_fault,
  // Accepted word and its rising bits.
  output logic      [CMD_W-1:0] accepted_q,
  output logic      [CMD_W-1:0] rise_q,
  output logic                  watchdog_bit_q
);

  logic [CMD_W-1:0] next_word;

  // A write only counts while its data-valid bit is high; a watchdog fault forces the default.
  always_comb begin
    next_word = accepted_q;
    if (wdog_fault) begin
      next_word = CMD_DEFAULT;
    end else if (word_wr && word_in[B_DATA_VALID]) begin
      next_word = word_in;
    end
  end

  // Accepted word, cleared to the default by reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accepted_q <= CMD_DEFAULT;
    end else begin
      accepted_q <= next_word;
    end
  end

  // Rising bits of the new word against the previously accepted one, one cycle wide.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rise_q <= '0;
    end else begin
      rise_q <= next_word & ~accepted_q;
    end
  end

  // The watchdog bit follows every write, whatever the data-valid bit says.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_bit_q <= 1'b0;
    end else if (word_wr) begin
      watchdog_bit_q <= word_in[B_WATCHDOG];
    end
  end

endmodule : cmd_word_latch

`default_nettype wire

/* core/grid_converter_command_decoder.sv */
/*
  Grid converter command decoder: turns the fieldbus command word into start-up and
  power-down requests and runs the basic start-up state machine.
  Assumes all inputs come from logic on clk; status inputs are levels from the power stage.
*/
`timescale 1ns/1ps
`default_nettype none

module grid_converter_command_decoder
  import gcc_decoder_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Command word port.
  input  wire logic [CMD_W-1:0] cmd_word_in,
  input  wire logic             cmd_word_wr,
  // Configuration levels.
  input  wire logic             edge_start_mode,
  input  wire logic             app_precharge_ctrl,
  input  wire logic             qstop_exception_en,
  // Power stage and supervision status.
  input  wire logic             wdog_fault,
  input  wire logic             fault_active,
  input  wire logic             start_permitted,
  input  wire logic             charge_done,
  input  wire logic             main_breaker_closed,
  // Requests and reports.
  output power_req_t            power_req_q,
  output logic      [CMD_W-1:0] condition_word_q,
  output start_state_t          state_q,
  output logic      [CMD_W-1:0] command_word_q,
  output logic      [3:0]       cfg_bits_q,
  output logic      [6:0]       app_bits_q,
  output logic                  watchdog_bit_q
);

  logic [CMD_W-1:0] accepted;
  logic [CMD_W-1:0] rise;
  logic             wdog_bit;
  logic             sw_on;
  logic             brk_en;
  logic             qstop_n;
  logic             start;
  logic             pre_bit;
  logic             start_rise;
  logic             event_rise;
  logic             start_arm_q;
  logic             arm_now;
  start_state_t     state_d;
  power_req_t       req_d;
  logic             qstop_hit;

  // Accepted word store and edge flags.
  cmd_word_latch u_latch (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .word_in        (cmd_word_in),
    .word_wr        (cmd_word_wr),
    .wdog_fault     (wdog_fault),
    .accepted_q     (accepted),
    .rise_q         (rise),
    .watchdog_bit_q (wdog_bit)
  );

  // Start-up bits come from bits 0 to 4 of the accepted word, the event reset edge from bit 7.
  assign sw_on      = accepted[B_SWITCH_ON];
  assign brk_en     = accepted[B_BREAKER_EN];
  assign qstop_n    = accepted[B_QSTOP_N];
  assign start      = accepted[B_START];
  assign pre_bit    = accepted[B_PRECHARGE];
  assign start_rise = rise[B_START];
  assign event_rise = rise[B_EVENT_RESET];

  // A start edge arms the start; in edge mode an edge that cannot be used is dropped.
  always_comb begin
    arm_now = start_rise;
    if (edge_start_mode && !start_permitted) begin
      arm_now = 1'b0;
    end
  end

  // Start arm holds from its edge until the start bit falls, the state leaves ready, or start is not permitted in edge mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_arm_q <= 1'b0;
    end else if (!start || state_q != ST_READY) begin
      start_arm_q <= 1'b0;
    end else if (arm_now) begin
      start_arm_q <= 1'b1;
    end else if (edge_start_mode && !start_permitted) begin
      start_arm_q <= 1'b0;
    end
  end

  // Next state, checked from the highest priority down: fault and breaker enable, switch-on,
  // quick stop, then start.
  always_comb begin
    state_d   = state_q;
    qstop_hit = 1'b0;
    if (fault_active || !brk_en) begin
      state_d = ST_INHIBITED;
    end else begin
      case (state_q)
        ST_INHIBITED: begin
          if (!sw_on) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (sw_on && qstop_n && start && start_permitted && (start_arm_q || arm_now)) begin
            state_d = ST_PRECHARGE;
          end
        end
        ST_PRECHARGE, ST_CLOSE, ST_RUN: begin
          if (!sw_on) begin
            state_d = ST_READY;
          end else if (!qstop_n) begin
            state_d   = ST_READY;
            qstop_hit = (state_q == ST_RUN);
          end else if (!start) begin
            state_d = ST_READY;
          end else if (state_q == ST_PRECHARGE) begin
            if (app_precharge_ctrl && !pre_bit) begin
              state_d = ST_READY;
            end else if (charge_done) begin
              state_d = ST_CLOSE;
            end
          end else if (state_q == ST_CLOSE) begin
            if (main_breaker_closed) begin
              state_d = ST_RUN;
            end
          end
        end
        default: begin
          state_d = ST_INHIBITED;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_INHIBITED;
    end else begin
      state_q <= state_d;
    end
  end

  // Requests follow the next state so they line up with the state register.
  always_comb begin
    req_d                 = REQ_IDLE;
    req_d.precharge       = (state_d == ST_PRECHARGE);
    req_d.breaker_close   = (state_d == ST_CLOSE) && !main_breaker_closed;
    req_d.breaker_open    = main_breaker_closed && state_d != ST_CLOSE && state_d != ST_RUN;
    req_d.run             = (state_d == ST_RUN) && sw_on && start;
    req_d.modulation_stop = !qstop_n;
    req_d.qstop_exception = qstop_hit && qstop_exception_en;
    req_d.event_reset     = event_rise;
  end

  // Request register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_req_q <= REQ_IDLE;
    end else begin
      power_req_q <= req_d;
    end
  end

  // Condition word reports the reached state and the enables.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      condition_word_q <= '0;
    end else begin
      condition_word_q                <= '0;
      condition_word_q[C_READY_ON]    <= sw_on && brk_en && qstop_n && !fault_active;
      condition_word_q[C_POWER_READY] <= (state_d == ST_RUN) || (state_d == ST_CLOSE);
      condition_word_q[C_OP_ENABLED]  <= (state_d == ST_RUN);
      condition_word_q[C_FAULT]       <= fault_active;
      condition_word_q[C_QSTOP_N]     <= qstop_n;
      condition_word_q[C_INHIBITED]   <= (state_d == ST_INHIBITED);
    end
  end

  // Accepted word, application field, configurable field and watchdog bit for other logic.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      command_word_q <= CMD_DEFAULT;
      cfg_bits_q     <= '0;
      app_bits_q     <= '0;
      watchdog_bit_q <= 1'b0;
    end else begin
      command_word_q <= accepted;
      cfg_bits_q     <= accepted[B_CFG_HI:B_CFG_LO];
      app_bits_q     <= accepted[B_APP_HI:B_APP_LO];
      watchdog_bit_q <= wdog_bit;
    end
  end

endmodule : grid_converter_command_decoder

`default_nettype wire

/* verif/gcc_decoder_properties.sv */
/*
  Port checker for the grid converter command decoder.
  Assumes one clock and a synchronous active-high reset; bound to the decoder below.
*/
`timescale 1ns/1ps
`default_nettype none

module gcc_decoder_properties
  import gcc_decoder_pkg::*;
(
  // Clock and reset.
  input wire logic             clk,
  input wire logic             sys_rst,
  // Watched inputs.
  input wire logic [CMD_W-1:0] cmd_word_in,
  input wire logic             cmd_word_wr,
  input wire logic             wdog_fault,
  input wire logic             fault_active,
  // Watched outputs.
  input wire power_req_t       power_req_q,
  input wire logic [CMD_W-1:0] command_word_q,
  input wire logic [CMD_W-1:0] condition_word_q,
  input wire start_state_t     state_q,
  input wire logic             watchdog_bit_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A write that the decoder must accept.
  sequence s_valid_wr;
    cmd_word_wr && cmd_word_in[B_DATA_VALID] && !wdog_fault;
  endsequence
  // The event bit has just appeared in the accepted word.
  sequence s_evt_rise;
    command_word_q[B_EVENT_RESET] && !$past(command_word_q[B_EVENT_RESET]);
  endsequence

  // Word acceptance, refusal and the default word.
  chk_valid_taken: assert property (s_valid_wr |=> ##1 (command_word_q == $past(cmd_word_in, 2)))
    else $error("accepted word not copied");
  chk_invalid_held: assert property (cmd_word_wr && !cmd_word_in[B_DATA_VALID] && !wdog_fault |=> ##1
    $stable(command_word_q)) else $error("invalid word changed command");
  chk_wdog_default: assert property (wdog_fault |=> ##1 (command_word_q == CMD_DEFAULT))
    else $error("default word not applied");
  chk_wdog_bit: assert property (cmd_word_wr |=> ##1 (watchdog_bit_q == $past(cmd_word_in[B_WATCHDOG], 2)))
    else $error("watchdog bit not taken");
  // Requests follow the state and the accepted word; the state follows breaker enable and the fault.
  chk_precharge_state: assert property (power_req_q.precharge == (state_q == ST_PRECHARGE))
    else $error("precharge request mismatch");
  chk_precharge_start: assert property ($rose(power_req_q.precharge) |-> $past(state_q) == ST_READY)
    else $error("precharge began outside ready");
  chk_run_enable: assert property (power_req_q.run |-> state_q == ST_RUN && command_word_q[B_SWITCH_ON]
    && command_word_q[B_START]) else $error("run without enables");
  chk_qstop_mod: assert property (power_req_q.modulation_stop == !command_word_q[B_QSTOP_N])
    else $error("modulation stop mismatch");
  chk_breaker_inhibit: assert property (!command_word_q[B_BREAKER_EN] |-> state_q == ST_INHIBITED)
    else $error("breaker enable low but not inhibited");
  chk_fault_inhibit: assert property (fault_active |=> state_q == ST_INHIBITED)
    else $error("fault did not inhibit");
  chk_event_edge: assert property (power_req_q.event_reset |-> s_evt_rise)
    else $error("event reset without rising bit");
  chk_event_pulse: assert property (power_req_q.event_reset |=> !power_req_q.event_reset)
    else $error("event reset longer than one cycle");
  // Ready-to-switch-on follows the enables of the accepted word and the fault seen one edge earlier.
  chk_ready_on_bit: assert property (condition_word_q[C_READY_ON] == (command_word_q[B_SWITCH_ON]
    && command_word_q[B_BREAKER_EN] && command_word_q[B_QSTOP_N] && !$past(fault_active)))
    else $error("ready to switch on mismatch");
  // A quick-stop exception only marks a drop from run to ready with quick stop requested.
  chk_qstop_exc: assert property (power_req_q.qstop_exception |-> state_q == ST_READY
    && $past(state_q) == ST_RUN && !command_word_q[B_QSTOP_N]) else $error("quick stop exception misplaced");
endmodule : gcc_decoder_properties

bind grid_converter_command_decoder gcc_decoder_properties u_gcc_decoder_properties (.clk, .sys_rst,
  .cmd_word_in, .cmd_word_wr, .wdog_fault, .fault_active, .power_req_q, .command_word_q, .state_q, .watchdog_bit_q,
  .condition_word_q);

`default_nettype wire

/* verif/fieldbus_ctrl_model.sv */
/*
  Model of the remote fieldbus controller that writes the command word.
  Assumes the decoder samples the word on the rising edge while the strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none

module fieldbus_ctrl_model
  import gcc_decoder_pkg::*;
(
  // Clock.
  input  wire logic             clk,
  // Command word toward the decoder.
  output logic      [CMD_W-1:0] cmd_word_in,
  output logic                  cmd_word_wr
);
  // Idle bus: no strobe, and the word shows a value that must be ignored.
  initial begin
    cmd_word_in = 16'hFFFF;
    cmd_word_wr = 1'b0;
  end

  // One write after some idle cycles; the word is inverted once the strobe drops.
  task automatic send(input logic [CMD_W-1:0] w, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    cmd_word_in = w;
    cmd_word_wr = 1'b1;
    @(negedge clk);
    cmd_word_wr = 1'b0;
    cmd_word_in = ~w;
  endtask : send
endmodule : fieldbus_ctrl_model

`default_nettype wire

/* verif/grid_converter_command_decoder_tb.sv */
/*
  Self-checking testbench for the grid converter command decoder.
  Assumes the controller model writes words; the bench drives status levels on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module grid_converter_command_decoder_tb;
  import gcc_decoder_pkg::*;

  logic             clk, sys_rst, edge_start_mode, app_precharge_ctrl, qstop_exception_en;
  logic             wdog_fault, fault_active, start_permitted, charge_done, main_breaker_closed;
  logic [CMD_W-1:0] cmd_word_in, command_word_q, condition_word_q;
  logic             cmd_word_wr, watchdog_bit_q;
  logic [3:0]       cfg_bits_q;
  logic [6:0]       app_bits_q;
  power_req_t       power_req_q;
  start_state_t     state_q;
  int               n_mismatch, samples_checked;

  fieldbus_ctrl_model u_fieldbus_ctrl_model (.clk, .cmd_word_in, .cmd_word_wr);
  grid_converter_command_decoder u_grid_converter_command_decoder (.clk, .sys_rst, .cmd_word_in, .cmd_word_wr,
    .edge_start_mode, .app_precharge_ctrl, .qstop_exception_en, .wdog_fault, .fault_active, .start_permitted,
    .charge_done, .main_breaker_closed, .power_req_q, .condition_word_q, .state_q, .command_word_q,
    .cfg_bits_q, .app_bits_q, .watchdog_bit_q);

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // Writes a word and waits until the state and requests have moved.
  task automatic put(input logic [15:0] w);
    u_fieldbus_ctrl_model.send(w, 0);
    step(1);
  endtask : put

  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hang short.
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {sys_rst, edge_start_mode, app_precharge_ctrl, qstop_exception_en} = 4'h8;
    {wdog_fault, fault_active, start_permitted, charge_done, main_breaker_closed} = 5'h00;
    n_mismatch = 0;
    samples_checked = 0;
    step(8);
    sys_rst = 1'b0;
    check(command_word_q, 16'h0005);
    check(16'(state_q), 16'(ST_INHIBITED));
    put(16'h0402);
    check(16'(state_q), 16'(ST_READY));
    put(16'h0407);
    check(16'(condition_word_q[C_READY_ON]), 16'h0001);
    start_permitted = 1'b1;
    put(16'h040F);
    check(16'(power_req_q.precharge), 16'h0001);
    charge_done = 1'b1;
    step(1);
    check(16'(power_req_q.breaker_close), 16'h0001);
    main_breaker_closed = 1'b1;
    step(1);
    check(16'(power_req_q.run), 16'h0001);
    check(condition_word_q, 16'h0027);
    // Quick stop from run, with the exception enabled and the breaker still closed.
    qstop_exception_en = 1'b1;
    put(16'h040B);
    check(16'(state_q), 16'(ST_READY));
    check({13'h0000, power_req_q.qstop_exception, power_req_q.modulation_stop, power_req_q.breaker_open}, 16'h0007);
    // A word without the valid bit only moves the watchdog bit.
    put(16'h0807);
    check(command_word_q, 16'h040B);
    check(16'(watchdog_bit_q), 16'h0001);
    // Edge start: a rise while start is impossible is dropped.
    {main_breaker_closed, charge_done, start_permitted} = 3'h0;
    {edge_start_mode, app_precharge_ctrl} = 2'h3;
    put(16'h0417);
    put(16'h041F);
    start_permitted = 1'b1;
    step(2);
    check(16'(state_q), 16'(ST_READY));
    put(16'h0417);
    u_fieldbus_ctrl_model.send(16'h041F, 2);
    step(1);
    check(16'(state_q), 16'(ST_PRECHARGE));
    put(16'h040F);
    check(16'(state_q), 16'(ST_READY));
    // Event reset edge and field split.
    put(16'hF487);
    check(16'(power_req_q.event_reset), 16'h0001);
    check({5'h00, app_bits_q, cfg_bits_q}, 16'h048F);
    step(1);
    check(16'(power_req_q.event_reset), 16'h0000);
    fault_active = 1'b1;
    step(1);
    check(16'(state_q), 16'(ST_INHIBITED));
    fault_active = 1'b0;
    wdog_fault = 1'b1;
    step(1);
    wdog_fault = 1'b0;
    step(1);
    check(command_word_q, 16'h0005);
    report_and_stop();
  end
endmodule : grid_converter_command_decoder_tb

`default_nettype wire
